// >>> src/eps_port_select.sv
// expansion port output select: register file on apb plus output muxing
// assumes decoder core timing and converter samples are synchronous to pclk
`timescale 1ns/1ns
module eps_port_select (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire eps_pkg::eps_timing_t timing,
   input  wire eps_pkg::eps_adc_t    adc,
   input  wire logic [7:0]           video_data,
   input  wire logic                 realtime_code_in,
   output logic      [7:0]           port_data,
   output logic                      port_horiz_reference_pin,
   output logic                      port_vert_reference_pin,
   output logic                      lock_indicator,
   output logic                      sample_toggle_reference,
   output logic                      realtime_code_output,
   output logic                      realtime_code_output_oe
);
   eps_pkg::eps_ctrl_t ctrl;
   logic [31:0]        regs;
   logic [7:0]         hs_begin;
   logic [7:0]         hs_stop;
   logic [1:0]         hsync_fine_delay;
   logic               reg_we;
   logic [1:0]         reg_idx;
   logic               hit_store;
   logic               hit_any;
   logic [7:0]         store_rdata;
   logic [31:0]        rd_d;
   logic [31:0]        prdata_q;
   logic               access;
   logic [2:0]         dec;

   logic [10:0] pix_q, pix_d;
   logic [2:0]  sub_q, sub_d;
   logic [7:0]  step_q, step_d;
   logic        tog_q, tog_d;
   logic        hs_raw_q, hs_raw_d;
   logic [7:0]  hs_dly_q, hs_dly_d;
   logic        active_line_reference_q, active_line_reference_d;
   logic        hout_q, hout_d;
   logic        vout_q, vout_d;
   logic        lock_q, lock_d;
   logic [7:0]  data_q, data_d;
   logic        code_q, code_d;
   logic [7:0]  first_hold_q, first_hold_d;

   // map an apb address to a store index; unmapped gives valid low
   function automatic logic [2:0] decode(input logic [7:0] a);
      case (a)
         eps_pkg::ADDR_HSYNC_BEGIN: decode = 3'h4;
         eps_pkg::ADDR_HSYNC_STOP:  decode = 3'h5;
         eps_pkg::ADDR_FINE_DELAY:  decode = 3'h6;
         eps_pkg::ADDR_PORT_CTRL:   decode = 3'h7;
         default:                   decode = 3'h0;
      endcase
   endfunction

   // timing reference word: f, v, h flags with protection bits
   function automatic logic [7:0] trs_word(input logic f, input logic v, input logic h);
      trs_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction

   assign access    = psel && penable;
   assign dec       = decode(paddr);
   assign hit_store = dec[2];
   assign reg_idx   = dec[1:0];
   assign hit_any   = hit_store || paddr == eps_pkg::ADDR_STATUS || paddr == eps_pkg::ADDR_LINE_POS;
   assign reg_we    = access && pwrite && hit_store;
   // no wait state; the stored register read is registered during the setup phase
   assign pready    = access;
   assign pslverr   = access && !hit_any;

   eps_reg8 u_store (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (reg_we),
      .waddr   (reg_idx),
      .wdata   (pwdata[7:0]),
      .raddr   (reg_idx),
      .rdata   (store_rdata),
      .flat    (regs)
   );

   assign hs_begin         = regs[7:0];
   assign hs_stop          = regs[15:8];
   assign hsync_fine_delay = regs[16 + eps_pkg::POS_FINE_DELAY +: 2];
   assign ctrl             = regs[31:24];

   always_comb begin
      rd_d = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         if (paddr == eps_pkg::ADDR_STATUS) begin
            rd_d = {28'h0000000, timing.horiz_lock_status, timing.fast_lock, hout_q, vout_q};
         end else if (paddr == eps_pkg::ADDR_LINE_POS) begin
            rd_d = {21'h000000, pix_q};
         end else begin
            rd_d = 32'h0000_0000;
         end
      end else begin
         rd_d = prdata_q;
      end
   end

   // store reads arrive registered one cycle after setup, in the access phase
   assign prdata = hit_store ? {24'h000000, store_rdata} : prdata_q;

   // line position, eight-clock steps and toggle reference
   always_comb begin
      pix_d = pix_q + 11'h001;
      if (timing.line_start || pix_q == eps_pkg::LINE_PIXELS - 11'h001) begin
         pix_d = 11'h000;
      end
      tog_d  = timing.line_start ? 1'b1 : !tog_q;
      sub_d  = (timing.line_start || sub_q == eps_pkg::STEP_EIGHTH) ? 3'h0 : sub_q + 3'h1;
      step_d = step_q;
      if (timing.line_start) begin
         step_d = 8'h00;
      end else if (sub_q == eps_pkg::STEP_EIGHTH) begin
         step_d = step_q + 8'h01;
      end
   end

   // sync pulse, its fine delay line and the horizontal pin
   always_comb begin
      // pulse between begin and stop, eight-clock steps
      hs_raw_d = hs_raw_q;
      if (step_q == hs_begin) begin
         hs_raw_d = 1'b1;
      end
      if (step_q == hs_stop) begin
         hs_raw_d = 1'b0;
      end
      hs_dly_d = {hs_dly_q[6:0], hs_raw_q};
      // 720 active pixels, runs through blanking too
      active_line_reference_d = pix_d < eps_pkg::ACTIVE_PIXELS;
      hout_d = ctrl.horiz_out_select ? hs_dly_q[{hsync_fine_delay, 1'b1}] : active_line_reference_q;
   end

   // vertical, lock and code pins
   always_comb begin
      case (ctrl.vert_out_select)
         2'h0:    vout_d = timing.vertical_sync_pulse;
         2'h1:    vout_d = timing.field_id;
         2'h2:    vout_d = !timing.vertical_sync_pulse;
         default: vout_d = !timing.field_id;
      endcase
      lock_d = ctrl.lock_indicator_select ? timing.fast_lock : !timing.horiz_lock_status;
      code_d = realtime_code_in;
   end

   // port data byte by output format
   always_comb begin
      first_hold_d = first_hold_q;
      data_d = video_data;
      case (ctrl.fmt)
         eps_pkg::FMT_ITU656, eps_pkg::FMT_ITU_GATE: begin
            // gated variant blanks outside the vertical gate window
            if ((ctrl.fmt == eps_pkg::FMT_ITU_GATE ? !timing.vertical_gate_window : timing.vert_blank)
                && active_line_reference_d) begin
               data_d = tog_d ? eps_pkg::BLANK_C : eps_pkg::BLANK_Y;
            end
            if (pix_d == eps_pkg::LINE_PIXELS - 11'h004 || pix_d == eps_pkg::ACTIVE_PIXELS) begin
               data_d = eps_pkg::TRS_FF;
            end else if (pix_d == eps_pkg::LINE_PIXELS - 11'h003 || pix_d == eps_pkg::LINE_PIXELS - 11'h002
                         || pix_d == eps_pkg::ACTIVE_PIXELS + 11'h001
                         || pix_d == eps_pkg::ACTIVE_PIXELS + 11'h002) begin
               data_d = eps_pkg::TRS_00;
            end else if (pix_d == eps_pkg::LINE_PIXELS - 11'h001) begin
               data_d = trs_word(timing.field_id, timing.vert_blank, 1'b0);
            end else if (pix_d == eps_pkg::ACTIVE_PIXELS + 11'h003) begin
               data_d = trs_word(timing.field_id, timing.vert_blank, 1'b1);
            end
         end
         eps_pkg::FMT_YUV_RAW: data_d = video_data;
         // bits 8..1, second on high, first on low
         eps_pkg::FMT_BYP_HI: begin
            if (adc.both_converters) begin
               data_d = tog_d ? adc.second_converter[8:1] : adc.first_converter[8:1];
            end else begin
               data_d = adc.use_second ? adc.second_converter[8:1] : adc.first_converter[8:1];
            end
         end
         eps_pkg::FMT_BYP_LO: begin
            if (adc.both_converters) begin
               data_d = tog_d ? adc.second_converter[7:0] : adc.first_converter[7:0];
            end else begin
               data_d = adc.use_second ? adc.second_converter[7:0] : adc.first_converter[7:0];
            end
         end
         // one sample over two cycles; low half held from the high cycle
         eps_pkg::FMT_BYP_SPLIT: begin
            if (tog_d) begin
               data_d = adc.use_second ? adc.second_converter[8:1] : adc.first_converter[8:1];
               first_hold_d = adc.use_second ? adc.second_converter[7:0] : adc.first_converter[7:0];
            end else begin
               data_d = first_hold_q;
            end
         end
         // reserved codes are left undefined by software; pass the video stream
         default: data_d = video_data;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix_q  <= 11'h000;
         sub_q  <= 3'h0;
         step_q <= 8'h00;
         tog_q  <= 1'b0;
      end else begin
         pix_q  <= pix_d;
         sub_q  <= sub_d;
         step_q <= step_d;
         tog_q  <= tog_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_raw_q <= 1'b0;
         hs_dly_q <= 8'h00;
         active_line_reference_q   <= 1'b0;
         hout_q   <= 1'b0;
      end else begin
         hs_raw_q <= hs_raw_d;
         hs_dly_q <= hs_dly_d;
         active_line_reference_q   <= active_line_reference_d;
         hout_q   <= hout_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vout_q <= 1'b0;
         lock_q <= 1'b0;
         code_q <= 1'b0;
      end else begin
         vout_q <= vout_d;
         lock_q <= lock_d;
         code_q <= code_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q       <= 8'h00;
         first_hold_q <= 8'h00;
      end else begin
         data_q       <= data_d;
         first_hold_q <= first_hold_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= rd_d;
      end
   end

   assign port_data                = data_q;
   assign port_horiz_reference_pin = hout_q;
   assign port_vert_reference_pin  = vout_q;
   assign lock_indicator           = lock_q;
   assign sample_toggle_reference  = tog_q;
   assign realtime_code_output     = code_q;
   assign realtime_code_output_oe  = ctrl.code_pin_output_enable;
endmodule // eps_port_select

// >>> src/eps_pkg.sv
// package for the expansion port output select block
// assumes an apb master on pclk; registers take one aligned 32-bit word each
package eps_pkg;

   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_HSYNC_BEGIN = 6'h06;
   localparam logic [5:0] IDX_HSYNC_STOP  = 6'h07;
   localparam logic [5:0] IDX_FINE_DELAY  = 6'h11;
   localparam logic [5:0] IDX_PORT_CTRL   = 6'h13;

   localparam logic [7:0] ADDR_HSYNC_BEGIN = {IDX_HSYNC_BEGIN, 2'b00};
   localparam logic [7:0] ADDR_HSYNC_STOP  = {IDX_HSYNC_STOP, 2'b00};
   localparam logic [7:0] ADDR_FINE_DELAY  = {IDX_FINE_DELAY, 2'b00};
   localparam logic [7:0] ADDR_PORT_CTRL   = {IDX_PORT_CTRL, 2'b00};
   localparam logic [7:0] ADDR_STATUS      = 8'h80;
   localparam logic [7:0] ADDR_LINE_POS    = 8'h84;

   localparam logic [7:0] RST_HSYNC_BEGIN = 8'h00;
   localparam logic [7:0] RST_HSYNC_STOP  = 8'h00;
   localparam logic [7:0] RST_FINE_DELAY  = 8'h00;
   localparam logic [7:0] RST_PORT_CTRL   = 8'h00;

   localparam int BIT_CODE_OE    = 7;
   localparam int BIT_HORIZ_SEL  = 6;
   localparam int POS_VERT_SEL   = 4;
   localparam int BIT_LOCK_SEL   = 3;
   localparam int POS_FINE_DELAY = 4;

   // pixels per line, active pixels and the last sub-count of an eight-clock step
   localparam logic [10:0] LINE_PIXELS   = 11'h6b4;
   localparam logic [10:0] ACTIVE_PIXELS = 11'h2d0;
   localparam logic [2:0]  STEP_EIGHTH   = 3'h7;

   // itu 656 timing reference words and blanking levels
   localparam logic [7:0] TRS_FF   = 8'hff;
   localparam logic [7:0] TRS_00   = 8'h00;
   localparam logic [7:0] BLANK_Y  = 8'h10;
   localparam logic [7:0] BLANK_C  = 8'h80;

   typedef enum logic [2:0] {
      FMT_ITU656   = 3'h0,
      FMT_ITU_GATE = 3'h1,
      FMT_YUV_RAW  = 3'h2,
      FMT_RSVD3    = 3'h3,
      FMT_BYP_HI   = 3'h4,
      FMT_BYP_LO   = 3'h5,
      FMT_RSVD6    = 3'h6,
      FMT_BYP_SPLIT = 3'h7
   } eps_fmt_t;

   typedef struct packed {
      logic       code_pin_output_enable;
      logic       horiz_out_select;
      logic [1:0] vert_out_select;
      logic       lock_indicator_select;
      eps_fmt_t   fmt;
   } eps_ctrl_t;

   // timing inputs from the decoder core
   typedef struct packed {
      logic vertical_sync_pulse;
      logic field_id;
      logic vertical_gate_window;
      logic vert_blank;
      logic horiz_lock_status;
      logic fast_lock;
      logic line_start;
   } eps_timing_t;

   typedef struct packed {
      logic       both_converters;
      logic       use_second;
      logic [8:0] first_converter;
      logic [8:0] second_converter;
   } eps_adc_t;

endpackage

// >>> src/eps_reg8.sv
// small 8-bit register store addressed by a 2-bit index, registered read
// assumes writes and reads come from the apb slave in the same clock domain
`timescale 1ns/1ns
module eps_reg8 (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       we,
   input  wire logic [1:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [1:0] raddr,
   output logic      [7:0] rdata,
   output logic      [31:0] flat
);
   logic [3:0][7:0] mem_q;
   logic [3:0][7:0] mem_d;
   logic [7:0]      rdata_d;

   always_comb begin
      mem_d = mem_q;
      if (we) begin
         mem_d[waddr] = wdata;
      end
      rdata_d = mem_d[raddr];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_q <= {eps_pkg::RST_PORT_CTRL, eps_pkg::RST_FINE_DELAY,
                   eps_pkg::RST_HSYNC_STOP, eps_pkg::RST_HSYNC_BEGIN};
         rdata <= 8'h00;
      end else begin
         mem_q <= mem_d;
         rdata <= rdata_d;
      end
   end

   assign flat = mem_q;
endmodule // eps_reg8

// >>> tb/eps_port_select_asserts.sv
// checker on the port select pins and its apb handshake
// assumes one pclk domain; the control register is shadowed from apb writes
`timescale 1ns/1ns
module eps_port_select_asserts (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [7:0]           paddr,
   input wire logic [31:0]          pwdata,
   input wire logic                 pready,
   input wire eps_pkg::eps_timing_t timing,
   input wire eps_pkg::eps_adc_t    adc,
   input wire logic                 realtime_code_in,
   input wire logic [7:0]           port_data,
   input wire logic                 port_horiz_reference_pin,
   input wire logic                 port_vert_reference_pin,
   input wire logic                 lock_indicator,
   input wire logic                 sample_toggle_reference,
   input wire logic                 realtime_code_output,
   input wire logic                 realtime_code_output_oe
);
   logic [7:0] ctrl_q, ctrl_d;
   logic [1:0] up_q, up_d;
   logic       v_exp;
   // shadow so pin checks know the selected mode; up_q hides the toggle restart after reset
   always_comb begin
      ctrl_d = ctrl_q;
      if (psel && penable && pwrite && paddr == eps_pkg::ADDR_PORT_CTRL)
         ctrl_d = pwdata[7:0];
      up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
      v_exp = (ctrl_q[4] ? timing.field_id : timing.vertical_sync_pulse) ^ ctrl_q[5];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 8'h00;
         up_q   <= 2'h0;
      end else begin
         ctrl_q <= ctrl_d;
         up_q   <= up_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (pready == (psel && penable))
      else $error("pready differs from access phase");
   a_oe_tracks_ctrl: assert property (realtime_code_output_oe == ctrl_q[7])
      else $error("code enable differs from control");
   a_code_copy: assert property (
      realtime_code_output_oe && $past(realtime_code_output_oe) |-> realtime_code_output == $past(realtime_code_in))
      else $error("code pin is not the delayed input");
   a_vert_select: assert property (1'b1 |=> port_vert_reference_pin == $past(v_exp))
      else $error("vertical pin wrong for select");
   a_lock_std: assert property (
      up_q != 2'h0 && !ctrl_q[3] |=> lock_indicator == !$past(timing.horiz_lock_status))
      else $error("lock pin not inverted status");
   a_lock_fast: assert property (ctrl_q[3] |=> lock_indicator == $past(timing.fast_lock))
      else $error("lock pin not fast indicator");
   a_toggle_alt: assert property (
      up_q == 2'h3 && !timing.line_start && !$past(timing.line_start) && !$past(timing.line_start, 2)
      |=> sample_toggle_reference != $past(sample_toggle_reference))
      else $error("toggle pin missed a change");
   a_active_line_reference_start: assert property (!ctrl_q[6] && timing.line_start |-> ##[1:3] port_horiz_reference_pin)
      else $error("active reference not raised at line start");
   a_bypass_high: assert property (
      ctrl_q[2:0] == 3'h4 && adc.both_converters
      |=> !sample_toggle_reference || port_data == $past(adc.second_converter[8:1]))
      else $error("high half is not second converter");
   c_split: cover property (ctrl_q[2:0] == 3'h7 && sample_toggle_reference);
   c_fast_lock: cover property (ctrl_q[3] && lock_indicator);
   c_hs_rise: cover property (ctrl_q[6] && $rose(port_horiz_reference_pin));
endmodule // eps_port_select_asserts

bind eps_port_select eps_port_select_asserts eps_port_select_asserts_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .timing, .adc, .realtime_code_in,
   .port_data, .port_horiz_reference_pin, .port_vert_reference_pin, .lock_indicator,
   .sample_toggle_reference, .realtime_code_output, .realtime_code_output_oe);

// >>> tb/eps_video_sink.sv
// downstream video sink: splits the multiplexed port stream by the toggle pin
// assumes port pins are registered on pclk
`timescale 1ns/1ns
module eps_video_sink (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] port_data,
   input  wire logic       sample_toggle_reference,
   output logic      [7:0] hi_byte_q,
   output logic      [7:0] lo_byte_q
);
   logic [7:0] hi_byte_d, lo_byte_d;
   always_comb begin
      hi_byte_d = hi_byte_q;
      lo_byte_d = lo_byte_q;
      if (sample_toggle_reference)
         hi_byte_d = port_data;
      else
         lo_byte_d = port_data;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_byte_q <= 8'h00;
         lo_byte_q <= 8'h00;
      end else begin
         hi_byte_q <= hi_byte_d;
         lo_byte_q <= lo_byte_d;
      end
   end
endmodule // eps_video_sink

// >>> tb/test_expansion_port_output_select.sv
// bench: apb tasks set the control registers, then pins and sink are compared
// assumes zero-wait apb and a decoder line of one pixel per pclk
`timescale 1ns/1ns
module test_expansion_port_output_select;
   localparam logic [7:0] CTRL = eps_pkg::ADDR_PORT_CTRL;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                 hpin, vpin, lck, tog, c_in, c_out, c_oe, hit;
   logic [7:0]           paddr, vdat, pdat, hi_b, lo_b;
   logic [31:0]          pwdata, prdata, rd, err;
   eps_pkg::eps_timing_t timing;
   eps_pkg::eps_adc_t    adc;
   int                   n_mismatch, compares, t0, t1, w;
   logic [7:0]           ex_hi [3] = '{8'h61, 8'hc3, 8'hd2};
   logic [7:0]           ex_lo [3] = '{8'hd2, 8'ha5, 8'ha5};
   logic [7:0]           fmts [3] = '{8'h04, 8'h05, 8'h07};
   logic [7:0]           radr [4] = '{8'h18, 8'h1c, 8'h44, 8'h4c};

   eps_port_select eps_port_select_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timing(timing), .adc(adc), .video_data(vdat), .realtime_code_in(c_in), .port_data(pdat),
      .port_horiz_reference_pin(hpin), .port_vert_reference_pin(vpin), .lock_indicator(lck),
      .sample_toggle_reference(tog), .realtime_code_output(c_out), .realtime_code_output_oe(c_oe));
   eps_video_sink eps_video_sink_i (.pclk(pclk), .presetn(presetn), .port_data(pdat),
      .sample_toggle_reference(tog), .hi_byte_q(hi_b), .lo_byte_q(lo_b));

   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one transfer; the request is held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) @(posedge pclk) n++;
      if (pready !== 1'b1) begin
         n_mismatch++;
         results();
      end
      rd = prdata;
      err = {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // cycles from line start to the horizontal pin rise, then its high width
   // a first line start flushes any pulse left from the free-running step count
   task automatic measure(output int rise, output int width);
      int n;
      rise = 0;
      width = 0;
      n = 0;
      timing.line_start <= 1'b1;
      @(posedge pclk);
      timing.line_start <= 1'b0;
      cyc(100);
      while (hpin !== 1'b0 && n < 4000) @(posedge pclk) n++;
      timing.line_start <= 1'b1;
      @(posedge pclk);
      timing.line_start <= 1'b0;
      while (hpin !== 1'b1 && rise < 4000) @(posedge pclk) rise++;
      while (hpin === 1'b1 && width < 4000) @(posedge pclk) width++;
      if (n >= 4000 || rise >= 4000 || width >= 4000) begin
         n_mismatch++;
         results();
      end
   endtask
   // only bytes with hpin high count, and hpin lags the port by one cycle, so the first timing code byte counts; two cycles let the new mode reach the port
   task automatic scan(input logic [7:0] v);
      hit = 1'b0;
      cyc(2);
      repeat (1800) @(posedge pclk) if (pdat === v && hpin === 1'b1) hit = 1'b1;
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, c_in} = '0;
      vdat = 8'h55;
      timing = '0;
      adc = '{both_converters:1'b1, use_second:1'b0, first_converter:9'h1a5, second_converter:9'h0c3};
      n_mismatch = 0;
      compares = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (radr[i]) begin
         apb(1'b0, radr[i], 32'h0);
         chk("reset value", rd, 32'h0);
      end
      apb(1'b1, CTRL, 32'hffff_ff32);
      apb(1'b0, CTRL, 32'h0);
      chk("control readback", rd, 32'h32);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", err, 32'h1);
      $display("test registers done");
      timing.vertical_sync_pulse <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, CTRL, 32'(s << 4));
         cyc(3);
         chk("vertical pin", {31'h0, vpin}, {31'h0, s == 0 || s == 3});
      end
      timing.horiz_lock_status <= 1'b1;
      timing.fast_lock <= 1'b1;
      apb(1'b1, CTRL, 32'h00);
      cyc(3);
      chk("lock standard", {31'h0, lck}, 32'h0);
      apb(1'b1, CTRL, 32'h08);
      cyc(3);
      chk("lock fast", {31'h0, lck}, 32'h1);
      c_in <= 1'b1;
      apb(1'b1, CTRL, 32'h80);
      cyc(3);
      chk("code pin on", {30'h0, c_oe, c_out}, 32'h3);
      apb(1'b1, CTRL, 32'h00);
      cyc(1);
      chk("code pin off", {31'h0, c_oe}, 32'h0);
      $display("test pin selects done");
      for (int i = 0; i < 3; i++) begin
         // one converter for the split code
         adc.both_converters <= (i < 2);
         apb(1'b1, CTRL, {24'h0, fmts[i]});
         cyc(4);
         chk("bypass high", {24'h0, hi_b}, {24'h0, ex_hi[i]});
         chk("bypass low", {24'h0, lo_b}, {24'h0, ex_lo[i]});
      end
      $display("test bypass done");
      apb(1'b1, CTRL, 32'h02);
      scan(8'hff);
      chk("no timing codes", {31'h0, hit}, 32'h0);
      apb(1'b1, CTRL, 32'h00);
      scan(8'hff);
      chk("timing codes", {31'h0, hit}, 32'h1);
      apb(1'b1, CTRL, 32'h01);
      scan(8'h55);
      chk("gate closed blanks", {31'h0, hit}, 32'h0);
      timing.vertical_gate_window <= 1'b1;
      scan(8'h55);
      chk("gate open passes", {31'h0, hit}, 32'h1);
      $display("test formats done");
      apb(1'b1, eps_pkg::ADDR_HSYNC_BEGIN, 32'h2);
      apb(1'b1, eps_pkg::ADDR_HSYNC_STOP, 32'h4);
      apb(1'b1, CTRL, 32'h40);
      measure(t0, w);
      chk("sync width", 32'(w), 32'd16);
      apb(1'b1, eps_pkg::ADDR_FINE_DELAY, 32'h30);
      measure(t1, w);
      chk("sync shift", 32'(t1 - t0), 32'd6);
      apb(1'b1, CTRL, 32'h00);
      measure(t0, w);
      chk("active width", 32'(w), 32'd720);
      $display("test horizontal done");
      results();
   end
endmodule // test_expansion_port_output_select
